//--- rtl/tpp_port.sv
// Purpose : pin level port logic of an eight channel timer, apb slave
// Assumes : timer engines sit on clk; pins are asynchronous
// Notes   : zero wait state slave; unmapped addresses answer pslverr
`timescale 1ns/100ps
`default_nettype none

module tpp_port (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // timer engines, same clock
  input  wire tpp_pkg::tpp_timer_ctl_t timer_ctl,
  input  wire logic [10:0]            event_pulse,
  output logic      [7:0]             pin_level_bits,
  // pins
  input  wire logic [7:0]             pin_in,
  output tpp_pkg::tpp_pin_drive_t     pin_drive,
  // interrupts
  output logic      [10:0]            irq_request,
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]  timer_pin_data_latch_q;
  logic [7:0]  timer_pin_data_latch_d;
  logic [7:0]  timer_pin_direction_q;
  logic [7:0]  timer_pin_direction_d;
  logic [10:0] irq_flags_q;
  logic [10:0] irq_flags_d;
  logic [10:0] irq_enable_q;
  logic [10:0] irq_enable_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  tpp_pkg::tpp_pin_drive_t drive_q;
  tpp_pkg::tpp_pin_drive_t drive_d;

  logic [7:0]  pin_sync;
  logic [7:0]  compare_owns;
  logic [7:0]  pin_oe_d;
  logic [7:0]  pin_lvl_d;
  logic [7:0]  data_read;
  logic [10:0] flag_clear;
  logic [10:0] pending;

  logic        setup_phase;
  logic        access_wr;
  logic        hit_data;
  logic        hit_dir;
  logic        hit_flags;
  logic        hit_enable;
  logic        hit_pend;
  logic        hit_level;
  logic        hit_any;
  logic        mapped_q;
  logic        mapped_d;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // word match on the byte offset, low two bits ignored
  function automatic logic reg_hit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    reg_hit = (addr[11:2] == offset[11:2]);
  endfunction : reg_hit

  // one match per register, reused by read and write paths
  assign hit_data   = reg_hit(paddr, tpp_pkg::OFF_DATA_LATCH);
  assign hit_dir    = reg_hit(paddr, tpp_pkg::OFF_DIRECTION);
  assign hit_flags  = reg_hit(paddr, tpp_pkg::OFF_IRQ_FLAGS);
  assign hit_enable = reg_hit(paddr, tpp_pkg::OFF_IRQ_ENABLE);
  assign hit_pend   = reg_hit(paddr, tpp_pkg::OFF_IRQ_PEND);
  assign hit_level  = reg_hit(paddr, tpp_pkg::OFF_PIN_LEVEL);
  assign hit_any    = hit_data | hit_dir | hit_flags
                    | hit_enable | hit_pend | hit_level;

  // bus phases: reads sampled in setup, writes applied in access
  assign setup_phase = psel & ~penable;
  assign access_wr   = psel & penable & pwrite;

  ////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  // pulses need two clocks
  // capture and edge inputs only seen after two stages
  tpp_sync #(
    .WIDTH (tpp_pkg::PINS)
  ) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // synchronised levels go on to the capture and edge engines
  assign pin_level_bits = pin_sync;

  ////////////////////////////////////////////////////////////////////////
  // per pin steering

  genvar g;
  generate
    for (g = 0; g < tpp_pkg::PINS; g++) begin : g_pin
      // compare forces output
      // an output compare owns the pin only when its output is enabled
      assign compare_owns[g] = timer_ctl.channel_function_select[g]
                             & timer_ctl.compare_pin_enable[g];

      assign pin_oe_d[g] = compare_owns[g] | timer_pin_direction_q[g];

      assign pin_lvl_d[g] = compare_owns[g] ? timer_ctl.compare_level[g]
                                            : timer_pin_data_latch_q[g];

      // read latch or pin
      // read follows direction bit even while compare drives the pin
      assign data_read[g] = timer_pin_direction_q[g] ? timer_pin_data_latch_q[g]
                                                     : pin_sync[g];
    end
  endgenerate

  // registered pin drive
  assign drive_d.oe    = pin_oe_d;
  assign drive_d.level = pin_lvl_d;

  ////////////////////////////////////////////////////////////////////////
  // port register writes

  // write touches latch only
  // the pin level is chosen above, so a compare-owned pin keeps its level
  assign timer_pin_data_latch_d = (access_wr & hit_data) ? pwdata[7:0]
                                                         : timer_pin_data_latch_q;

  assign timer_pin_direction_d = (access_wr & hit_dir) ? pwdata[7:0]
                                                       : timer_pin_direction_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags and enables

  // write one to clear, zero bits leave the flag alone
  assign flag_clear = (access_wr & hit_flags) ? pwdata[10:0] : 11'h000;

  // eleven sticky flags
  // a new event in the clearing cycle keeps the flag set
  assign irq_flags_d = (irq_flags_q & ~flag_clear) | event_pulse;

  // local enables, one per source
  assign irq_enable_d = (access_wr & hit_enable) ? pwdata[10:0] : irq_enable_q;

  assign pending = irq_flags_q & irq_enable_q;

  ////////////////////////////////////////////////////////////////////////
  // read data

  // read word selected in setup, held in a flop for the access phase
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_data) begin
      prdata_d[7:0] = data_read;
    end else if (hit_dir) begin
      prdata_d[7:0] = timer_pin_direction_q;
    end else if (hit_flags) begin
      prdata_d[10:0] = irq_flags_q;
    end else if (hit_enable) begin
      prdata_d[10:0] = irq_enable_q;
    end else if (hit_pend) begin
      prdata_d[10:0] = pending;
    end else if (hit_level) begin
      prdata_d[7:0] = pin_sync;
    end
  end

  // read word and mapped flag are loaded only in setup
  assign mapped_d = setup_phase ? hit_any : mapped_q;

  ////////////////////////////////////////////////////////////////////////
  // state registers

  // reset makes all inputs
  // port registers and pin drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_pin_data_latch_q <= tpp_pkg::RST_DATA_LATCH;
      timer_pin_direction_q  <= tpp_pkg::RST_DIRECTION;
      drive_q                <= '0;
    end else begin
      timer_pin_data_latch_q <= timer_pin_data_latch_d;
      timer_pin_direction_q  <= timer_pin_direction_d;
      drive_q                <= drive_d;
    end
  end

  // interrupt flags and enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flags_q  <= tpp_pkg::RST_IRQ_FLAGS;
      irq_enable_q <= tpp_pkg::RST_IRQ_ENABLE;
    end else begin
      irq_flags_q  <= irq_flags_d;
      irq_enable_q <= irq_enable_d;
    end
  end

  // bus read word and decode result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
      mapped_q <= 1'b0;
    end else begin
      prdata_q <= setup_phase ? prdata_d : prdata_q;
      mapped_q <= mapped_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states; error only in the access phase of an unmapped word
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped_q;
  assign prdata  = prdata_q;

  // pins
  assign pin_drive = drive_q;

  assign irq_request = pending;
  assign irq         = |pending;

endmodule : tpp_port

`default_nettype wire

//--- rtl/tpp_sync.sv
// Purpose : two flop synchroniser for asynchronous pin levels
// Assumes : input may change at any time relative to clk
// Notes   : first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module tpp_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two stages, constant reset values only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : tpp_sync

`default_nettype wire

//--- shared/tpp_pkg.sv
// Purpose : constants and types shared by the timer port pin logic
// Assumes : apb with 32-bit data, one aligned word per register
// Notes   : offsets are byte addresses
package tpp_pkg;

  // port geometry
  localparam int unsigned PINS      = 8;
  localparam int unsigned SOURCES   = 11;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned SYNC_LEN  = 2;

  // register byte offsets
  localparam logic [11:0] OFF_DATA_LATCH = 12'h000;
  localparam logic [11:0] OFF_DIRECTION  = 12'h004;
  localparam logic [11:0] OFF_IRQ_FLAGS  = 12'h008;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h00C;
  localparam logic [11:0] OFF_IRQ_PEND   = 12'h010;
  localparam logic [11:0] OFF_PIN_LEVEL  = 12'h014;

  // reset values
  localparam logic [7:0]  RST_DATA_LATCH = 8'h00;
  localparam logic [7:0]  RST_DIRECTION  = 8'h00;
  localparam logic [10:0] RST_IRQ_FLAGS  = 11'h000;
  localparam logic [10:0] RST_IRQ_ENABLE = 11'h000;

  // interrupt source positions in flag, enable and pending words
  localparam int unsigned SRC_CH0          = 0;
  localparam int unsigned SRC_COUNTER_WRAP = 8;
  localparam int unsigned SRC_EDGE_WRAP    = 9;
  localparam int unsigned SRC_EDGE_INPUT   = 10;

  // drive state of the eight shared pins
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } tpp_pin_drive_t;

  // view of the timer channels that steer the pins
  typedef struct packed {
    logic [7:0] channel_function_select;
    logic [7:0] compare_pin_enable;
    logic [7:0] compare_level;
  } tpp_timer_ctl_t;

endpackage : tpp_pkg

//--- testbench/tpp_pin_board.sv
// Purpose: board circuitry on the eight shared pins
// Assumes: port drives where oe is set, board drives the rest
// Notes: board levels are held four edges at least
`timescale 1ns/100ps
`default_nettype none
module tpp_pin_board (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire tpp_pkg::tpp_pin_drive_t pin_drive,
  input  wire logic [7:0]              ext_level,
  output logic      [7:0]              pin_in
);
  logic [7:0] held_q;
  logic [1:0] hold_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_q <= 8'h00;
      hold_q <= 2'h0;
    end else if (hold_q == 2'h0) begin
      held_q <= ext_level;
      hold_q <= 2'h3;
    end else begin
      hold_q <= hold_q - 2'h1;
    end
  end
  // wire level: driven bits follow the port
  assign pin_in = (pin_drive.oe & pin_drive.level) | (~pin_drive.oe & held_q);
endmodule : tpp_pin_board
`default_nettype wire

//--- testbench/tpp_port_asserts.sv
// Purpose: assertions on the timer port pins, apb and interrupts
// Assumes: zero wait apb, pin drive lands one edge after its cause
// Notes: shadows of direction, latch and enables follow apb writes
`timescale 1ns/100ps
`default_nettype none
module tpp_port_asserts (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire tpp_pkg::tpp_timer_ctl_t timer_ctl,
  input wire logic [10:0]             event_pulse,
  input wire logic [7:0]              pin_level_bits,
  input wire tpp_pkg::tpp_pin_drive_t pin_drive,
  input wire logic [10:0]             irq_request,
  input wire logic                    irq
);
  logic [7:0]  dir_q;
  logic [7:0]  latch_q;
  logic [10:0] en_q;
  // decode of writes and the expected pin ownership
  wire logic        wr     = psel & penable & pwrite;
  wire logic [7:0]  own    = timer_ctl.channel_function_select & timer_ctl.compare_pin_enable;
  wire logic [7:0]  cmp    = timer_ctl.compare_level & own;
  wire logic [7:0]  gp_out = dir_q & ~own;
  wire logic [7:0]  rd_mix = (latch_q & dir_q) | (pin_level_bits & ~dir_q);
  wire logic [10:0] clr    = pwdata[10:0] & ~event_pulse;
  // shadow registers, updated at the apb write edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_q   <= 8'h00;
      latch_q <= 8'h00;
      en_q    <= 11'h000;
    end else if (wr) begin
      if (paddr[11:2] == 10'h000) latch_q <= pwdata[7:0];
      if (paddr[11:2] == 10'h001) dir_q <= pwdata[7:0];
      if (paddr[11:2] == 10'h003) en_q <= pwdata[10:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_oe_compare: assert property ($past(reset_n) |->
    (pin_drive.oe & $past(own)) == $past(own)) else $error("compare pin not driven");
  chk_oe_direction: assert property ($past(reset_n) |->
    (pin_drive.oe & ~$past(own)) == ($past(dir_q) & ~$past(own)))
    else $error("pin direction wrong");
  chk_lvl_compare: assert property ($past(reset_n) |->
    (pin_drive.level & $past(own)) == $past(cmp)) else $error("compare level wrong");
  chk_lvl_latch: assert property ($past(reset_n) |->
    (pin_drive.level & $past(gp_out)) == ($past(latch_q) & $past(gp_out)))
    else $error("latch level wrong");
  chk_rst_inputs: assert property (!$past(reset_n) |-> pin_drive.oe == 8'h00)
    else $error("pin driven after reset");
  chk_read_mix: assert property (psel && !penable && !pwrite && paddr[11:2] == 10'h000
    |=> prdata[7:0] == $past(rd_mix)) else $error("data read mix wrong");
  chk_err_map: assert property (psel && penable |->
    pready && pslverr == (paddr[11:2] > 10'h005)) else $error("apb answer wrong");
  chk_irq_rise: assert property ((event_pulse & en_q) != 11'h000 && !wr |=>
    (irq_request & $past(event_pulse)) == ($past(event_pulse) & $past(en_q)))
    else $error("request not raised");
  chk_irq_masked: assert property ((irq_request & ~en_q) == 11'h000)
    else $error("masked request high");
  chk_irq_clear: assert property (wr && paddr[11:2] == 10'h002 |=>
    (irq_request & $past(clr)) == 11'h000) else $error("request not cleared");
  chk_irq_or: assert property (irq == (|irq_request)) else $error("irq not or");
  cov_read: cover property (psel && !penable && !pwrite && paddr[11:2] == 10'h000);
  cov_own: cover property (own == 8'hFF);
  cov_irq: cover property ($rose(irq));
endmodule : tpp_port_asserts
bind tpp_port tpp_port_asserts u_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_ctl(timer_ctl), .event_pulse(event_pulse), .pin_level_bits(pin_level_bits),
  .pin_drive(pin_drive), .irq_request(irq_request), .irq(irq));
`default_nettype wire

//--- testbench/tpp_port_bench.sv
// Purpose: self checking bench of the timer port pin logic
// Assumes: seeded random pins, directions and compare setups
// Notes: expectations are computed in the bench itself, by exp_read and inline expressions
`timescale 1ns/100ps
`default_nettype none
module tpp_port_bench;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed;
  logic pready, pslverr;
  tpp_pkg::tpp_timer_ctl_t timer_ctl = '0;
  tpp_pkg::tpp_pin_drive_t pin_drive;
  logic [10:0] event_pulse = 11'h000, irq_request, mask;
  logic [7:0] pin_level_bits, pin_in, ext_level = 8'h00;
  logic [7:0] dir, lat, ext, sel, en, lvl, own, oe, lv;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  tpp_port u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ctl(timer_ctl), .event_pulse(event_pulse),
    .pin_level_bits(pin_level_bits), .pin_in(pin_in), .pin_drive(pin_drive),
    .irq_request(irq_request), .irq(irq));
  tpp_pin_board u_board (.clk(clk), .reset_n(reset_n), .pin_drive(pin_drive),
    .ext_level(ext_level), .pin_in(pin_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // the wait ends once pready is seen high; the hang guard ends one that never does
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic logic [7:0] exp_read(input logic [7:0] d, l, o, v, x);
    return (d & l) | (~d & ((o & v) | (~o & x)));
  endfunction : exp_read
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    seed = $urandom(71);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check({24'h0, pin_drive.oe}, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 12; k++) begin
      {dir, lat, ext, sel, en, lvl} = 48'({$urandom, $urandom});
      if (k == 0) {dir, sel, en} = {8'h00, 8'hFF, 8'hFF};
      timer_ctl <= {sel, en, lvl};
      ext_level <= ext;
      apb(1'b1, 12'h004, {24'h0, dir});
      apb(1'b1, 12'h000, {24'h0, lat});
      repeat (10) @(posedge clk);
      own = sel & en;
      oe = own | dir;
      lv = (own & lvl) | (~own & lat);
      check({16'h0, pin_drive.level & oe, pin_drive.oe}, {16'h0, lv & oe, oe});
      apb(1'b0, 12'h000, 32'h0);
      check(rd, {24'h0, exp_read(dir, lat, oe, lv, ext)});
      apb(1'b0, 12'h004, 32'h0);
      check(rd, {24'h0, dir});
      // synchronised pin levels, on the bus and towards the engines
      apb(1'b0, 12'h014, 32'h0);
      check(rd, {24'h0, exp_read(8'h00, lat, oe, lv, ext)});
      check({24'h0, pin_level_bits}, {24'h0, exp_read(8'h00, lat, oe, lv, ext)});
      timer_ctl <= {sel, 8'h00, lvl};
      repeat (2) @(posedge clk);
      check({24'h0, pin_drive.oe}, {24'h0, dir});
    end
    mask = 11'($urandom);
    apb(1'b1, 12'h00C, {21'h0, mask});
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, {21'h0, mask});
    for (int i = 0; i < 11; i++) begin
      event_pulse <= 11'h001 << i;
      @(posedge clk);
      event_pulse <= 11'h000;
      @(posedge clk);
      check({20'h0, irq, irq_request}, {20'h0, mask[i], mask & (11'h001 << i)});
      apb(1'b0, 12'h008, 32'h0);
      check(rd, {21'h0, 11'h001 << i});
      apb(1'b1, 12'h010, 32'h7FF);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, {21'h0, mask & (11'h001 << i)});
      apb(1'b1, 12'h008, {21'h0, 11'h001 << i});
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0);
    end
    // corner: an event in the clearing cycle keeps its flag set
    event_pulse <= 11'h100;
    fork
      apb(1'b1, 12'h008, 32'h100);
      begin
        repeat (2) @(posedge clk);
        event_pulse <= 11'h000;
      end
    join
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h100);
    apb(1'b1, 12'h008, 32'h100);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], err}, 32'h1);
    conclude();
  end
endmodule : tpp_port_bench
`default_nettype wire
